// [shared/pmw_pkg.sv]
// Package for the power mode and wake-up controller
package pmw_pkg;
	localparam logic [7:0] CTRL_ZERO_ADDR = 8'h00;
	localparam logic [7:0] WAKE_EN_ADDR = 8'h01;
	localparam logic [7:0] STATUS_ADDR = 8'h02;
	localparam logic [7:0] CFG_ADDR = 8'h03;
	localparam int CLKSEL_BIT = 0;
	localparam int LOWPWR_BIT = 1;
	localparam int PWRDN_BIT = 0;
	localparam int EXPIRED_BIT = 1;
	localparam logic [7:0] CTRL_ZERO_RESET = 8'h00;
	localparam logic [7:0] WAKE_EN_RESET = 8'h00;
	localparam int CLK_HZ = 10000000;
	localparam int SHORT_WAIT_CLKS = 2;
	localparam int LONG_WAIT_CLKS = 128;
	localparam int POWERON_DELAY_MS = 50;
	localparam int POWERON_DELAY_CLKS = POWERON_DELAY_MS * (CLK_HZ / 1000);
	// Fast oscillator configuration option
	typedef enum logic [1:0] {
		PMW_OSC_RC_XTAL, PMW_OSC_RC, PMW_OSC_FAST_XTAL, PMW_OSC_EXT_RC
	} pmw_osc_t;
	// Watchdog clock source option
	typedef enum logic [1:0] {PMW_DOG_SLOW_RC, PMW_DOG_XTAL, PMW_DOG_SYS} pmw_dogsrc_t;
	typedef enum logic [2:0] {
		PMW_RUN, PMW_IDLE, PMW_SLEEP, PMW_WAIT_POR, PMW_WAIT_SST
	} pmw_mode_t;
	typedef struct packed {
		logic lowpwr;
		logic clksel;
	} pmw_ctrl_t;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} pmw_bus_t;
	typedef struct packed {
		logic fast_rc_run;
		logic slow_xtal_run;
		logic slow_xtal_lowpwr;
		logic slow_rc_run;
		logic sys_use_slow;
		logic sys_clk_en;
		logic watchdog_clear;
		logic watchdog_run;
	} pmw_osc_ctl_t;
	typedef struct packed {
		logic resume;
		logic vector_irq;
		logic pc_sp_reset;
		logic full_reset;
	} pmw_wake_t;
endpackage

// [hw/pmw_ctrl.sv]
// Power mode, clock select and wake-up controller
`timescale 1ns/1ns
module pmw_ctrl #(
	parameter int POWERON_CLKS = pmw_pkg::POWERON_DELAY_CLKS
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire pmw_pkg::pmw_bus_t bus_i,
	output logic [7:0] rdata_o,
	input wire pmw_pkg::pmw_osc_t osc_cfg_i,
	input wire pmw_pkg::pmw_dogsrc_t watchdog_src_i,
	input wire logic slow_rc_enable_i,
	input wire logic halt_i,
	input wire logic watchdog_clear_instr_i,
	input wire logic [7:0] port_a_i,
	input wire logic ext_rst_n_i,
	input wire logic watchdog_overflow_i,
	input wire logic irq_req_i,
	input wire logic irq_enabled_i,
	input wire logic stack_full_i,
	output pmw_pkg::pmw_osc_ctl_t osc_o,
	output pmw_pkg::pmw_wake_t wake_o,
	output logic halted_o
);
	import pmw_pkg::*;

	localparam int CW = $clog2(POWERON_CLKS + LONG_WAIT_CLKS + 1);

	typedef struct packed {
		pmw_ctrl_t ctrl;
		logic [7:0] wake_en;
		logic powerdown_flag;
		logic to;
		pmw_mode_t mode;
		logic [CW-1:0] cnt;
		logic irq_masked;
		logic [7:0] pa_s1;
		logic [7:0] pa_s2;
		logic [7:0] pa_s3;
		logic [7:0] pa_lvl;
		logic rst_s1;
		logic rst_s2;
		logic rst_s3;
		logic rst_lvl;
		logic from_reset;
		logic vec;
		logic [7:0] rdata;
		pmw_osc_ctl_t osc;
		pmw_wake_t wake;
	} pmw_state_t;

	pmw_state_t s;
	pmw_state_t next_s;

	// True when crystal is on its pins (fast RC chosen as fast source)
	function automatic logic xtal_ok(input pmw_osc_t c);
		return c == PMW_OSC_RC_XTAL;
	endfunction

	// Startup wait for a non-reset wake depends on oscillator kind
	function automatic logic [CW-1:0] sst_len(input pmw_osc_t c);
		if (c == PMW_OSC_FAST_XTAL || c == PMW_OSC_RC_XTAL) begin
			return CW'(LONG_WAIT_CLKS);
		end
		return CW'(SHORT_WAIT_CLKS);
	endfunction

	logic [7:0] pa_fall;
	logic rst_low;
	logic halting;
	logic pa_wake;
	logic irq_wake;
	logic any_wake;

	// Agreed-sample edge detection on pins
	assign pa_fall = s.wake_en & s.pa_lvl & ~s.pa_s2 & ~s.pa_s3;
	assign rst_low = (s.rst_s2 == s.rst_s3) ? ~s.rst_s3 : ~s.rst_lvl;
	assign halting = (s.mode == PMW_IDLE) || (s.mode == PMW_SLEEP);
	assign pa_wake = halting && (|pa_fall);
	assign irq_wake = halting && irq_req_i && !s.irq_masked;
	assign any_wake = pa_wake || irq_wake || (halting && watchdog_overflow_i);

	always_comb begin
		next_s = s;
		next_s.wake = '0;
		next_s.osc.watchdog_clear = 1'b0;
		// Pin synchronisers
		next_s.pa_s1 = port_a_i;
		next_s.pa_s2 = s.pa_s1;
		next_s.pa_s3 = s.pa_s2;
		next_s.rst_s1 = ext_rst_n_i;
		next_s.rst_s2 = s.rst_s1;
		next_s.rst_s3 = s.rst_s2;
		if (s.rst_s2 == s.rst_s3) begin
			next_s.rst_lvl = s.rst_s3;
		end
		// Agreed port A level follows once two samples match
		next_s.pa_lvl = (~(s.pa_s2 ^ s.pa_s3) & s.pa_s3) | ((s.pa_s2 ^ s.pa_s3) & s.pa_lvl);
		// Register writes
		if (bus_i.wr) begin
			if (bus_i.addr == CTRL_ZERO_ADDR) begin
				next_s.ctrl.lowpwr = bus_i.wdata[LOWPWR_BIT];
				next_s.ctrl.clksel = bus_i.wdata[CLKSEL_BIT];
			end else if (bus_i.addr == WAKE_EN_ADDR) begin
				next_s.wake_en = bus_i.wdata;
			end
		end
		// Read data, one cycle later
		next_s.rdata = 8'h00;
		if (bus_i.rd) begin
			case (bus_i.addr)
				CTRL_ZERO_ADDR: next_s.rdata = {6'h00, s.ctrl.lowpwr, s.ctrl.clksel};
				WAKE_EN_ADDR: next_s.rdata = s.wake_en;
				STATUS_ADDR: next_s.rdata = {5'h00, halting, s.to, s.powerdown_flag};
				CFG_ADDR: next_s.rdata = {4'h0, 1'b0, slow_rc_enable_i, osc_cfg_i};
				default: next_s.rdata = 8'h00;
			endcase
		end
		// Watchdog clear instruction
		if (watchdog_clear_instr_i && s.mode == PMW_RUN) begin
			next_s.powerdown_flag = 1'b0;
			next_s.osc.watchdog_clear = 1'b1;
		end
		case (s.mode)
			PMW_RUN: begin
				if (halt_i) begin
					next_s.powerdown_flag = 1'b1;
					next_s.to = 1'b0;
					next_s.osc.watchdog_clear = 1'b1;
					next_s.irq_masked = irq_req_i;
					// Idle when crystal runs, Sleep otherwise
					next_s.mode = xtal_ok(osc_cfg_i) ? PMW_IDLE : PMW_SLEEP;
				end
			end
			PMW_IDLE, PMW_SLEEP: begin
				if (!irq_req_i) begin
					next_s.irq_masked = 1'b0;
				end
				if (any_wake) begin
					next_s.from_reset = 1'b0;
					next_s.vec = irq_wake && irq_enabled_i && !stack_full_i;
					if (watchdog_overflow_i) begin
						next_s.to = 1'b1;
						next_s.wake.pc_sp_reset = 1'b1;
						next_s.vec = 1'b0;
					end
					next_s.cnt = sst_len(osc_cfg_i);
					next_s.mode = PMW_WAIT_SST;
				end
			end
			PMW_WAIT_POR: begin
				if (s.cnt == '0) begin
					next_s.cnt = CW'(LONG_WAIT_CLKS);
					next_s.mode = PMW_WAIT_SST;
				end else begin
					next_s.cnt = s.cnt - 1'b1;
				end
			end
			PMW_WAIT_SST: begin
				if (s.cnt <= CW'(1)) begin
					next_s.mode = PMW_RUN;
					next_s.wake.resume = !s.from_reset;
					next_s.wake.vector_irq = s.vec && !s.from_reset;
				end else begin
					next_s.cnt = s.cnt - 1'b1;
				end
			end
			default: next_s.mode = PMW_RUN;
		endcase
		// External reset wins from any mode: full reset, power-on wait, then long wait
		if (rst_low) begin
			next_s.wake = '0;
			next_s.wake.full_reset = 1'b1;
			next_s.from_reset = 1'b1;
			next_s.vec = 1'b0;
			next_s.cnt = CW'(POWERON_CLKS - 1);
			next_s.mode = PMW_WAIT_POR;
		end
		// Oscillator steering from next mode
		next_s.osc.slow_xtal_run = xtal_ok(osc_cfg_i);
		next_s.osc.slow_xtal_lowpwr = next_s.ctrl.lowpwr && xtal_ok(osc_cfg_i);
		next_s.osc.sys_use_slow = next_s.ctrl.clksel && xtal_ok(osc_cfg_i);
		next_s.osc.sys_clk_en = !(next_s.mode == PMW_IDLE || next_s.mode == PMW_SLEEP);
		next_s.osc.fast_rc_run = next_s.osc.sys_clk_en && !next_s.osc.sys_use_slow;
		next_s.osc.slow_rc_run = slow_rc_enable_i;
		// Watchdog stops only if clocked from the stopped system clock
		next_s.osc.watchdog_run = next_s.osc.sys_clk_en || (watchdog_src_i != PMW_DOG_SYS);
	end

	// State register; crystal low-power select cleared at power-up
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s <= '0;
			s.ctrl <= pmw_ctrl_t'(CTRL_ZERO_RESET[1:0]);
			s.wake_en <= WAKE_EN_RESET;
			s.pa_s1 <= 8'hFF;
			s.pa_s2 <= 8'hFF;
			s.pa_s3 <= 8'hFF;
			s.pa_lvl <= 8'hFF;
			s.rst_s1 <= 1'b1;
			s.rst_s2 <= 1'b1;
			s.rst_s3 <= 1'b1;
			s.rst_lvl <= 1'b1;
			s.mode <= PMW_RUN;
			s.osc.sys_clk_en <= 1'b1;
			s.osc.fast_rc_run <= 1'b1;
			s.osc.watchdog_run <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign rdata_o = s.rdata;
	assign osc_o = s.osc;
	assign wake_o = s.wake;
	// Idle keeps crystal peripherals alive for wake interrupts
	assign halted_o = halting;

	property p_halt_flags;
		@(posedge clk_i) disable iff (rst_i)
		(s.mode == PMW_RUN && halt_i && !rst_low) |=> (s.powerdown_flag && !s.to && halting);
	endproperty
	a_halt_flags: assert property (p_halt_flags) else $error("halt flags wrong");

	property p_idle_sel;
		@(posedge clk_i) disable iff (rst_i)
		(s.mode == PMW_RUN && halt_i && !rst_low) |=>
			(s.mode == (xtal_ok(osc_cfg_i) ? PMW_IDLE : PMW_SLEEP));
	endproperty
	a_idle_sel: assert property (p_idle_sel) else $error("wrong halt mode");

	property p_sleep_stop;
		@(posedge clk_i) disable iff (rst_i)
		halting |-> (!osc_o.sys_clk_en && !osc_o.fast_rc_run);
	endproperty
	a_sleep_stop: assert property (p_sleep_stop) else $error("clock runs while halted");

	property p_xtal_run;
		@(posedge clk_i) disable iff (rst_i)
		(halting && xtal_ok(osc_cfg_i) && $stable(osc_cfg_i)) |-> osc_o.slow_xtal_run;
	endproperty
	a_xtal_run: assert property (p_xtal_run) else $error("crystal stopped");

	// Expiry wake sets the flag and restarts counter and stack
	property p_expire_wake;
		@(posedge clk_i) disable iff (rst_i)
		(halting && watchdog_overflow_i && !rst_low) |=> (s.to && wake_o.pc_sp_reset);
	endproperty
	a_expire_wake: assert property (p_expire_wake) else $error("expiry wake wrong");

	// RC setups resume two clocks after the wake edge
	property p_short_wait;
		@(posedge clk_i) disable iff (rst_i)
		(any_wake && !rst_low && (osc_cfg_i == PMW_OSC_RC || osc_cfg_i == PMW_OSC_EXT_RC))
			|=> !wake_o.resume ##1 !wake_o.resume ##1 wake_o.resume;
	endproperty
	a_short_wait: assert property (p_short_wait) else $error("short wait wrong");

	// Clear instruction drops the powerdown flag
	property p_clr_pdf;
		@(posedge clk_i) disable iff (rst_i)
		(s.mode == PMW_RUN && watchdog_clear_instr_i && !halt_i) |=> !s.powerdown_flag;
	endproperty
	a_clr_pdf: assert property (p_clr_pdf) else $error("powerdown flag not cleared");

	property p_clksel;
		@(posedge clk_i) disable iff (rst_i)
		(!xtal_ok(osc_cfg_i) && $stable(osc_cfg_i)) |-> !osc_o.sys_use_slow;
	endproperty
	a_clksel: assert property (p_clksel) else $error("slow clock without crystal");

	// Written low-power bit reaches the crystal
	property p_lowpwr_wr;
		@(posedge clk_i) disable iff (rst_i)
		(bus_i.wr && bus_i.addr == CTRL_ZERO_ADDR && xtal_ok(osc_cfg_i))
			|=> (osc_o.slow_xtal_lowpwr == $past(bus_i.wdata[LOWPWR_BIT]));
	endproperty
	a_lowpwr_wr: assert property (p_lowpwr_wr) else $error("low-power bit not applied");

	// Written clock select reaches the system clock mux
	property p_clksel_wr;
		@(posedge clk_i) disable iff (rst_i)
		(bus_i.wr && bus_i.addr == CTRL_ZERO_ADDR && xtal_ok(osc_cfg_i))
			|=> (osc_o.sys_use_slow == $past(bus_i.wdata[CLKSEL_BIT]));
	endproperty
	a_clksel_wr: assert property (p_clksel_wr) else $error("clock select not applied");

	// Slow mode stops the fast RC
	property p_fast_stop;
		@(posedge clk_i) disable iff (rst_i)
		osc_o.sys_use_slow |-> !osc_o.fast_rc_run;
	endproperty
	a_fast_stop: assert property (p_fast_stop) else $error("fast rc runs in slow mode");

	// Crystal pins taken by another fast source
	property p_xtal_off;
		@(posedge clk_i) disable iff (rst_i)
		(!xtal_ok(osc_cfg_i) && $stable(osc_cfg_i)) |-> !osc_o.slow_xtal_run;
	endproperty
	a_xtal_off: assert property (p_xtal_off) else $error("crystal runs without pins");

	// Watchdog on the system clock stops while halted
	property p_dog_stop;
		@(posedge clk_i) disable iff (rst_i)
		(halting && watchdog_src_i == PMW_DOG_SYS && $stable(watchdog_src_i))
			|-> !osc_o.watchdog_run;
	endproperty
	a_dog_stop: assert property (p_dog_stop) else $error("watchdog runs on stopped clock");

	// Watchdog on its own clock keeps counting while halted
	property p_dog_keep;
		@(posedge clk_i) disable iff (rst_i)
		(halting && watchdog_src_i != PMW_DOG_SYS && $stable(watchdog_src_i))
			|-> osc_o.watchdog_run;
	endproperty
	a_dog_keep: assert property (p_dog_keep) else $error("watchdog stopped while halted");

	// Halt clears the watchdog
	property p_halt_clear;
		@(posedge clk_i) disable iff (rst_i)
		(s.mode == PMW_RUN && halt_i && !rst_low) |=> osc_o.watchdog_clear;
	endproperty
	a_halt_clear: assert property (p_halt_clear) else $error("halt left watchdog");

	// Slow RC follows its configuration enable
	property p_slow_rc;
		@(posedge clk_i) disable iff (rst_i)
		(!$past(rst_i) && $stable(slow_rc_enable_i)) |-> (osc_o.slow_rc_run == slow_rc_enable_i);
	endproperty
	a_slow_rc: assert property (p_slow_rc) else $error("slow rc wrong");

	// Enabled pin fall starts the wake wait
	property p_pa_go;
		@(posedge clk_i) disable iff (rst_i)
		(pa_wake && !rst_low) |=> (s.mode == PMW_WAIT_SST);
	endproperty
	a_pa_go: assert property (p_pa_go) else $error("pin wake ignored");

	// Resume returns to run mode
	property p_resume_run;
		@(posedge clk_i) disable iff (rst_i)
		wake_o.resume |-> (s.mode == PMW_RUN && !halting);
	endproperty
	a_resume_run: assert property (p_resume_run) else $error("resume outside run");

	// Vector only together with resume
	property p_vec_resume;
		@(posedge clk_i) disable iff (rst_i)
		wake_o.vector_irq |-> wake_o.resume;
	endproperty
	a_vec_resume: assert property (p_vec_resume) else $error("vector without resume");

	// Enabled interrupt with stack room is vectored
	property p_irq_vec;
		@(posedge clk_i) disable iff (rst_i)
		(irq_wake && irq_enabled_i && !stack_full_i && !watchdog_overflow_i && !rst_low)
			|=> s.vec;
	endproperty
	a_irq_vec: assert property (p_irq_vec) else $error("interrupt vector lost");

	// Request pending at halt does not wake
	property p_irq_hold;
		@(posedge clk_i) disable iff (rst_i)
		(halting && s.irq_masked && !pa_wake && !watchdog_overflow_i && !rst_low) |=> halting;
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("pending request woke");

	// Reset pin forces full reset and power-on wait
	property p_ext_reset;
		@(posedge clk_i) disable iff (rst_i)
		rst_low |=> (wake_o.full_reset && s.mode == PMW_WAIT_POR && s.from_reset);
	endproperty
	a_ext_reset: assert property (p_ext_reset) else $error("reset pin ignored");

	// Reset wake ends with no resume pulse
	property p_reset_quiet;
		@(posedge clk_i) disable iff (rst_i)
		(s.from_reset && s.mode == PMW_WAIT_SST && s.cnt <= CW'(1)) |=> !wake_o.resume;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("resume after reset");

	// Crystal setups load the long wait
	property p_long_wait;
		@(posedge clk_i) disable iff (rst_i)
		(any_wake && !rst_low && (osc_cfg_i == PMW_OSC_FAST_XTAL || osc_cfg_i == PMW_OSC_RC_XTAL))
			|=> (s.cnt == CW'(LONG_WAIT_CLKS));
	endproperty
	a_long_wait: assert property (p_long_wait) else $error("long wait not loaded");

	// Registers hold while halted
	property p_regs_keep;
		@(posedge clk_i) disable iff (rst_i)
		(halting && !bus_i.wr) |=> ($stable(s.ctrl) && $stable(s.wake_en));
	endproperty
	a_regs_keep: assert property (p_regs_keep) else $error("register changed while halted");
endmodule

// [bench/pmw_wake_src.sv]
// External wake-up sources: port A pins, reset pin, watchdog and interrupt lines
`timescale 1ns/1ns
module pmw_wake_src (
	input wire logic clk_i,
	output logic [7:0] port_a_o,
	output logic ext_rst_n_o,
	output logic dog_ov_o,
	output logic irq_o
);
	// Pins idle high on pull-ups, event lines idle low
	initial begin
		port_a_o = 8'hFF;
		ext_rst_n_o = 1'b1;
		dog_ov_o = 1'b0;
		irq_o = 1'b0;
	end
	// Drive one source at the next rising edge
	task automatic drive(input int k, input logic [7:0] v);
		@(posedge clk_i);
		case (k)
			0: port_a_o <= v;
			1: ext_rst_n_o <= v[0];
			2: dog_ov_o <= v[0];
			default: irq_o <= v[0];
		endcase
	endtask
endmodule

// [bench/pmw_ctrl_tb.sv]
// Self-checking bench for the power mode and wake-up controller
`timescale 1ns/1ns
module pmw_ctrl_tb;
	import pmw_pkg::*;
	logic clk_i = 0;
	logic rst_i = 1;
	pmw_bus_t bus_i = '0;
	pmw_osc_t cfg = PMW_OSC_RC_XTAL;
	pmw_dogsrc_t wsrc = PMW_DOG_SLOW_RC;
	logic slow_internal_rc = 1, halt = 0, wclr = 0, irq_en = 1, stk = 0, ps, vi, fr;
	logic [7:0] rdata_o, pa, rv, v;
	logic ern, wov, irq, halted;
	pmw_osc_ctl_t osc;
	pmw_wake_t wk;
	int err_total = 0, checked = 0, n, b;
	always #50 clk_i = ~clk_i;
	pmw_ctrl #(.POWERON_CLKS(20)) dut (.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus_i),
		.rdata_o(rdata_o), .osc_cfg_i(cfg), .watchdog_src_i(wsrc), .slow_rc_enable_i(slow_internal_rc),
		.halt_i(halt), .watchdog_clear_instr_i(wclr), .port_a_i(pa), .ext_rst_n_i(ern),
		.watchdog_overflow_i(wov), .irq_req_i(irq), .irq_enabled_i(irq_en),
		.stack_full_i(stk), .osc_o(osc), .wake_o(wk), .halted_o(halted));
	pmw_wake_src src (.clk_i(clk_i), .port_a_o(pa), .ext_rst_n_o(ern), .dog_ov_o(wov),
		.irq_o(irq));
	// Verdict and end of run
	task automatic close_out();
		$display("compares %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			err_total++;
			$display("mismatch %s expected %0h seen %0h", nm, e, s);
		end
	endtask
	task automatic step();
		@(posedge clk_i);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i) bus_i <= '{a, d, 1'b1, 1'b0};
		@(posedge clk_i) bus_i.wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i) bus_i <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk_i) bus_i.rd <= 1'b0;
		#1 d = rdata_o;
	endtask
	// One-cycle instruction pulse: 0 halt, 1 watchdog clear
	task automatic pulse(input int k);
		@(posedge clk_i);
		if (k == 0) halt <= 1'b1;
		else wclr <= 1'b1;
		@(posedge clk_i);
		halt <= 1'b0;
		wclr <= 1'b0;
		#1;
	endtask
	// Bounded wait for resume, noting watchdog and vector pulses
	task automatic wake_wait(input int start);
		n = start;
		#1;
		ps = wk.pc_sp_reset;
		fr = wk.full_reset;
		vi = 0;
		while (wk.resume !== 1'b1) begin
			step();
			n++;
			ps |= wk.pc_sp_reset;
			fr |= wk.full_reset;
			vi = wk.vector_irq;
			if (n > 400) begin
				chk("resume timeout", 1, 0);
				close_out();
			end
		end
	endtask
	task automatic do_halt();
		pulse(0);
		chk("halted", halted, 1);
		chk("dog_clear", osc.watchdog_clear, 1);
		chk("sys_clk_en", osc.sys_clk_en, 0);
		step();
		chk("dog_run", osc.watchdog_run, wsrc != PMW_DOG_SYS);
		chk("xtal_run halted", osc.slow_xtal_run, cfg == PMW_OSC_RC_XTAL);
		chk("slow_rc_run", osc.slow_rc_run, slow_internal_rc);
	endtask
	initial begin
		void'($urandom(66052));
		repeat (2) @(posedge clk_i);
		rst_i <= 0;
		rd(CTRL_ZERO_ADDR, rv);
		chk("ctrl_zero reset", rv, CTRL_ZERO_RESET);
		chk("lowpwr reset", osc.slow_xtal_lowpwr, 0);
		$display("reset test done");
		// Both clock selects, random low-power bit, every fast oscillator option
		for (int i = 0; i < 8; i++) begin
			cfg <= pmw_osc_t'(i / 2);
			v = {6'h00, 1'($urandom), 1'(i)};
			wr(CTRL_ZERO_ADDR, v);
			rd(CTRL_ZERO_ADDR, rv);
			chk("ctrl_zero", rv, v);
			step();
			chk("xtal_run", osc.slow_xtal_run, i < 2);
			chk("use_slow", osc.sys_use_slow, i == 1);
			if (i < 2) chk("lowpwr", osc.slow_xtal_lowpwr, v[1]);
			if (i < 4) chk("fast_rc_run", osc.fast_rc_run, i != 1);
		end
		$display("clock select test done");
		// Idle in crystal setup, woken by an enabled port A pin
		cfg <= PMW_OSC_RC_XTAL;
		wsrc <= PMW_DOG_SYS;
		slow_internal_rc <= 1'($urandom);
		b = $urandom % 8;
		wr(CTRL_ZERO_ADDR, 8'h02);
		wr(WAKE_EN_ADDR, 8'h01 << b);
		do_halt();
		src.drive(0, ~(8'h01 << b));
		wake_wait(0);
		chk("pa vector", vi, 0);
		src.drive(0, 8'hFF);
		rd(STATUS_ADDR, rv);
		chk("status after halt", rv, 1);
		rd(CFG_ADDR, rv);
		chk("config", rv, {5'h00, slow_internal_rc, cfg});
		pulse(1);
		rd(STATUS_ADDR, rv);
		chk("status after clear", rv, 0);
		$display("port wake test done");
		// Watchdog wake with RC timing
		cfg <= PMW_OSC_RC;
		wsrc <= PMW_DOG_SLOW_RC;
		do_halt();
		src.drive(2, 1);
		src.drive(2, 0);
		wake_wait(0);
		chk("rc wait", n, SHORT_WAIT_CLKS);
		chk("pc_sp_reset", ps, 1);
		rd(STATUS_ADDR, rv);
		chk("status wdt", rv, 3);
		$display("watchdog wake test done");
		// Interrupt wakes with crystal timing; pending request ignored
		cfg <= PMW_OSC_FAST_XTAL;
		for (int s = 0; s < 2; s++) begin
			stk <= 1'(s);
			if (s == 0) src.drive(3, 1);
			do_halt();
			repeat (10) step();
			chk("pending irq", halted, 1);
			src.drive(3, 0);
			src.drive(3, 1);
			wake_wait(-1);
			chk("xtal wait", n, LONG_WAIT_CLKS);
			chk("irq vector", vi, s == 0);
			src.drive(3, 0);
		end
		$display("interrupt wake test done");
		// External reset wake gives a full reset and no resume
		do_halt();
		src.drive(1, 0);
		repeat (5) step();
		src.drive(1, 1);
		for (int i = 0; i < 170; i++) begin
			step();
			fr |= wk.full_reset;
			if (i > 5) chk("reset no resume", wk.resume, 0);
		end
		chk("full_reset", fr, 1);
		$display("reset wake test done");
		close_out();
	end
endmodule
